// ===== core/iprb_pkg.sv
// Package of register map, field layout and reset values for the priority bank
package iprb_pkg;

   // ****************************************
   // Register indices (word offsets)
   // ****************************************
   localparam logic [3:0] IPRB_IDX_PRIO9 = 4'h0;
   localparam logic [3:0] IPRB_IDX_PRIO10 = 4'h1;
   localparam logic [3:0] IPRB_IDX_PRIO12 = 4'h2;
   localparam logic [3:0] IPRB_IDX_PRIO13 = 4'h3;
   localparam logic [3:0] IPRB_IDX_PRIO14 = 4'h4;
   localparam logic [3:0] IPRB_IDX_PRIO15 = 4'h5;
   localparam logic [3:0] IPRB_IDX_PRIO16 = 4'h6;
   localparam logic [3:0] IPRB_IDX_PRIO17 = 4'h7;
   localparam logic [3:0] IPRB_IDX_STATUS = 4'h8;
   localparam logic [3:0] IPRB_IDX_FLAG = 4'h9;
   localparam logic [3:0] IPRB_IDX_ENABLE = 4'hA;

   // ****************************************
   // Sources and fields
   // ****************************************
   localparam int IPRB_NSRC = 24;
   localparam logic [2:0] IPRB_PRIO_RST = 3'h4;
   localparam logic [2:0] IPRB_PRIO_OFF = 3'h0;
   localparam logic [6:0] IPRB_VEC_BASE = 7'h0C;
   // Implemented field bits per register, in index order
   localparam logic [15:0] IPRB_MASK [0:7] = '{16'h7777, 16'h7707, 16'h7777, 16'h7777,
                                              16'h0007, 16'h0070, 16'h0770, 16'h7777};

endpackage : iprb_pkg

// ===== core/iprb_regs.sv
// Priority register array with masked fields and level-four reset
`timescale 1ns/10ps
module iprb_regs
   import iprb_pkg::*;
(
   input wire logic clk_sys_i, // System clock
   input wire logic rst_i, // Async reset, high
   input wire logic wr_i, // Write strobe
   input wire logic [3:0] idx_i, // Register index
   input wire logic [15:0] wdata_i, // Write data
   output logic [15:0] regs_o [0:7] // Register contents
);

   typedef struct packed
   {
      logic [7:0][15:0] prio;
   } iprb_regs_state_type;

   iprb_regs_state_type st_r;
   iprb_regs_state_type st_nxt;

   // Writes land only in implemented bits
   always_comb
   begin
      st_nxt = st_r;
      if (wr_i && (idx_i <= IPRB_IDX_PRIO17))
      begin
         st_nxt.prio[idx_i[2:0]] = wdata_i & IPRB_MASK[idx_i[2:0]];
      end
   end

   // Every field starts at level four
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 8; i++)
         begin
            st_r.prio[i] <= {4{1'b0, IPRB_PRIO_RST}} & IPRB_MASK[i];
         end
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         regs_o[i] = st_r.prio[i];
      end
   end

endmodule : iprb_regs

// ===== core/iprb_arb.sv
// Combinational arbiter picking the highest pending enabled source
`timescale 1ns/10ps
module iprb_arb
   import iprb_pkg::*;
(
   input wire logic [IPRB_NSRC-1:0] req_i, // Flag and enable combined
   input wire logic [IPRB_NSRC*3-1:0] prio_i, // Level per source
   output logic valid_o, // Some source wins
   output logic [2:0] level_o, // Winning level
   output logic [4:0] src_o // Winning source index
);

   // Strictly-greater compare keeps the lowest index on ties
   always_comb
   begin
      valid_o = 1'b0;
      level_o = 3'h0;
      src_o = 5'h00;
      for (int i = 0; i < IPRB_NSRC; i++)
      begin
         if (req_i[i] && (prio_i[i*3 +: 3] != IPRB_PRIO_OFF)
             && (prio_i[i*3 +: 3] > level_o))
         begin
            valid_o = 1'b1;
            level_o = prio_i[i*3 +: 3];
            src_o = 5'(i);
         end
      end
   end

endmodule : iprb_arb

// ===== core/iprb_top.sv
// Upper interrupt priority register bank with request arbitration
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module iprb_top
   import iprb_pkg::*;
(
   input wire logic clk_sys_i, // System clock, 100 MHz
   input wire logic rst_i, // Async reset, high
   input wire logic [3:0] addr_i, // Register index
   input wire logic [15:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   input wire logic [IPRB_NSRC-1:0] src_flag_i, // Raw source requests
   output logic [15:0] rdata_o, // Read data, cycle after rd_i
   output logic irq_o, // Request to core
   output logic [2:0] irq_level_o, // Level of request
   output logic [6:0] irq_vec_o // Vector of request
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed
   {
      logic [15:0] rdata;
      logic irq;
      logic [2:0] level;
      logic [6:0] vec;
      logic [IPRB_NSRC-1:0] flag;
      logic [IPRB_NSRC-1:0] en;
   } iprb_state_type;

   iprb_state_type st_r;
   iprb_state_type st_nxt;
   logic [15:0] regs [0:7];
   logic [IPRB_NSRC*3-1:0] prio_flat;
   logic win_valid;
   logic [2:0] win_level;
   logic [4:0] win_src;

   // ****************************************
   // Helpers
   // ****************************************
   // Level field n of a priority word; bit 3 of each nibble is reserved
   function automatic logic [2:0] iprb_field(input logic [15:0] word, input int n);
      return word[n*4 +: 3];
   endfunction : iprb_field

   iprb_regs u_regs
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .wr_i(wr_i),
      .idx_i(addr_i),
      .wdata_i(wdata_i),
      .regs_o(regs)
   );

   // Gather fields in natural source order: four nibbles per register, low first
   always_comb
   begin
      prio_flat = '0;
      for (int r = 0; r < 6; r++)
      begin
         for (int n = 0; n < 4; n++)
         begin
            prio_flat[(r*4+n)*3 +: 3] = iprb_field(regs[(r < 4) ? r : r + 2], n);
         end
      end
   end

   // Six registers feed the 24 sources; fourteen and fifteen are stored only
   iprb_arb u_arb
   (
      .req_i(st_r.flag & st_r.en),
      .prio_i(prio_flat),
      .valid_o(win_valid),
      .level_o(win_level),
      .src_o(win_src)
   );

   // ****************************************
   // Bus and request logic
   // ****************************************
   always_comb
   begin
      st_nxt = st_r;
      // Hardware set wins over software clear
      st_nxt.flag = st_r.flag | src_flag_i;
      if (wr_i && addr_i == IPRB_IDX_FLAG)
      begin
         // An all-zero word clears all 24 flags; a raised source still wins
         st_nxt.flag = (wdata_i == 16'h0000) ? src_flag_i
            : ((st_r.flag & {8'hFF, wdata_i}) | src_flag_i);
      end
      if (wr_i && addr_i == IPRB_IDX_ENABLE)
      begin
         st_nxt.en = {8'h00, wdata_i};
      end
      st_nxt.rdata = 16'h0000;
      if (rd_i)
      begin
         if (addr_i <= IPRB_IDX_PRIO17)
         begin
            st_nxt.rdata = regs[addr_i[2:0]];
         end
         else if (addr_i == IPRB_IDX_STATUS)
         begin
            st_nxt.rdata = {4'h0, 1'b0, st_r.level, 1'b0, st_r.vec};
         end
         else if (addr_i == IPRB_IDX_FLAG)
         begin
            st_nxt.rdata = st_r.flag[15:0];
         end
         else if (addr_i == IPRB_IDX_ENABLE)
         begin
            st_nxt.rdata = st_r.en[15:0];
         end
      end
      st_nxt.irq = win_valid;
      st_nxt.level = win_level;
      st_nxt.vec = win_valid ? 7'(IPRB_VEC_BASE + 7'(win_src)) : 7'h00;
   end

   // Flops for bus answer, flags, enables and request outputs
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs come straight from the flops
   assign rdata_o = st_r.rdata;
   assign irq_o = st_r.irq;
   assign irq_level_o = st_r.level;
   assign irq_vec_o = st_r.vec;

   // ****************************************
   // Checks
   // ****************************************
   property p_off_blocks;
      @(posedge clk_sys_i) disable iff (rst_i)
      irq_o |-> irq_level_o != 3'h0;
   endproperty
   a_off_blocks: assert property (p_off_blocks) else $error("disabled level forwarded");

   property p_rst_four;
      @(posedge clk_sys_i) disable iff (rst_i)
      $fell(rst_i) |-> regs[0] == 16'h4444;
   endproperty
   a_rst_four: assert property (p_rst_four) else $error("reset level not four");

   property p_reg14;
      @(posedge clk_sys_i) disable iff (rst_i)
      regs[4][15:3] == 13'h0000;
   endproperty
   a_reg14: assert property (p_reg14) else $error("reg14 upper bits set");

   property p_reg15;
      @(posedge clk_sys_i) disable iff (rst_i)
      regs[5][15:7] == 9'h000 && regs[5][3:0] == 4'h0;
   endproperty
   a_reg15: assert property (p_reg15) else $error("reg15 reserved bits set");

   property p_unimpl;
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_i && addr_i <= IPRB_IDX_PRIO17 |=> (rdata_o & 16'h8888) == 16'h0000;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("reserved bit read one");

   property p_level_max;
      @(posedge clk_sys_i) disable iff (rst_i)
      win_valid |=> irq_o && irq_level_o == $past(win_level);
   endproperty
   a_level_max: assert property (p_level_max) else $error("level not presented");

   property p_seven;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st_r.flag[0] && st_r.en[0] && prio_flat[2:0] == 3'h7) |=> irq_level_o == 3'h7;
   endproperty
   a_seven: assert property (p_seven) else $error("code 111 not top");

   property p_one;
      @(posedge clk_sys_i) disable iff (rst_i)
      (irq_o && irq_level_o == 3'h1) |-> $past(win_level) == 3'h1;
   endproperty
   a_one: assert property (p_one) else $error("level one mismatch");

   // Software write to the flag word, shared by the flag checks
   logic flag_wr;
   assign flag_wr = wr_i && (addr_i == IPRB_IDX_FLAG);

   property p_flag_set;
      @(posedge clk_sys_i) disable iff (rst_i)
      src_flag_i != '0 |=> (st_r.flag & $past(src_flag_i)) == $past(src_flag_i);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("raised flag lost");

   property p_flag_clear;
      @(posedge clk_sys_i) disable iff (rst_i)
      flag_wr && wdata_i == 16'h0000 |=> st_r.flag == $past(src_flag_i);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("clear-all wrong");

   property p_flag_keep;
      @(posedge clk_sys_i) disable iff (rst_i)
      flag_wr && |wdata_i |=> st_r.flag[23:16] == $past(st_r.flag[23:16] | src_flag_i[23:16]);
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("upper flags disturbed");

   property p_flag_low;
      @(posedge clk_sys_i) disable iff (rst_i)
      flag_wr && |wdata_i
         |=> st_r.flag[15:0] == $past((st_r.flag[15:0] & wdata_i) | src_flag_i[15:0]);
   endproperty
   a_flag_low: assert property (p_flag_low) else $error("flag clear mask wrong");

   property p_none_idle;
      @(posedge clk_sys_i) disable iff (rst_i)
      !win_valid |=> !irq_o && irq_level_o == 3'h0 && irq_vec_o == 7'h00;
   endproperty
   a_none_idle: assert property (p_none_idle) else $error("request without source");

   property p_vec_map;
      @(posedge clk_sys_i) disable iff (rst_i)
      win_valid |=> irq_vec_o == 7'(IPRB_VEC_BASE + 7'($past(win_src)));
   endproperty
   a_vec_map: assert property (p_vec_map) else $error("vector not of winner");

   property p_unmapped;
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_i && addr_i > IPRB_IDX_ENABLE |=> rdata_o == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_rst_levels;
      @(posedge clk_sys_i) disable iff (rst_i)
      $fell(rst_i) |-> regs[1] == 16'h4404 && regs[4] == 16'h0004 && regs[5] == 16'h0040
         && regs[6] == 16'h0440 && regs[7] == 16'h4444;
   endproperty
   a_rst_levels: assert property (p_rst_levels) else $error("reset levels wrong");

   property p_write_lands;
      @(posedge clk_sys_i) disable iff (rst_i)
      wr_i && addr_i <= IPRB_IDX_PRIO17
         |=> regs[$past(addr_i[2:0])] == $past(wdata_i & IPRB_MASK[addr_i[2:0]]);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("write not landed");

   property p_tie_low;
      @(posedge clk_sys_i) disable iff (rst_i)
      st_r.flag[0] && st_r.en[0] && iprb_field(regs[0], 0) == 3'h7 |=> irq_vec_o == IPRB_VEC_BASE;
   endproperty
   a_tie_low: assert property (p_tie_low) else $error("first source lost tie");

   property p_zero_src0;
      @(posedge clk_sys_i) disable iff (rst_i)
      win_valid && prio_flat[2:0] == IPRB_PRIO_OFF |-> win_src != 5'h00;
   endproperty
   a_zero_src0: assert property (p_zero_src0) else $error("disabled source won");

   property p_rsv_all;
      @(posedge clk_sys_i) disable iff (rst_i)
      (regs[0] & ~IPRB_MASK[0]) == 16'h0000 && (regs[1] & ~IPRB_MASK[1]) == 16'h0000
         && (regs[2] & ~IPRB_MASK[2]) == 16'h0000 && (regs[3] & ~IPRB_MASK[3]) == 16'h0000
         && (regs[6] & ~IPRB_MASK[6]) == 16'h0000 && (regs[7] & ~IPRB_MASK[7]) == 16'h0000;
   endproperty
   a_rsv_all: assert property (p_rsv_all) else $error("reserved bit stored");

   property p_rd_status;
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_i && addr_i == IPRB_IDX_STATUS
         |=> rdata_o == {5'h00, $past(irq_level_o), 1'b0, $past(irq_vec_o)};
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read wrong");

   property p_field_read;
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_i && addr_i <= IPRB_IDX_PRIO17 |=> rdata_o == $past(regs[addr_i[2:0]]);
   endproperty
   a_field_read: assert property (p_field_read) else $error("priority read wrong");

   property p_upper_src;
      @(posedge clk_sys_i) disable iff (rst_i)
      win_valid |-> win_src < 5'h10;
   endproperty
   a_upper_src: assert property (p_upper_src) else $error("unenabled source won");

   property p_rst_outputs;
      @(posedge clk_sys_i) disable iff (rst_i)
      $fell(rst_i) |-> !irq_o && irq_vec_o == 7'h00 && rdata_o == 16'h0000;
   endproperty
   a_rst_outputs: assert property (p_rst_outputs) else $error("outputs busy after reset");

   property p_en_read;
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_i && addr_i == IPRB_IDX_ENABLE |=> rdata_o == $past(st_r.en[15:0]);
   endproperty
   a_en_read: assert property (p_en_read) else $error("enable read wrong");

endmodule : iprb_top

// ===== bench/iprb_core_model.sv
// Core-side model that takes the request the bank offers
`timescale 1ns/10ps
module iprb_core_model
(
   input wire logic clk_sys_i, // System clock
   input wire logic rst_i, // Async reset, high
   input wire logic irq_i, // Request from bank
   input wire logic [6:0] vec_i, // Offered vector
   output logic [6:0] taken_vec_o // Last vector taken
);
   // Take the vector whenever the request stands; no ack path exists
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         taken_vec_o <= 7'h00;
      else if (irq_i)
         taken_vec_o <= vec_i;
   end
endmodule : iprb_core_model

// ===== bench/testbench.sv
// Self-checking bench for the upper priority bank
`timescale 1ns/10ps
module testbench
   import iprb_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [IPRB_NSRC-1:0] src_flag_i = '0;
   logic [15:0] rdata_o;
   logic irq_o;
   logic [2:0] irq_level_o;
   logic [6:0] irq_vec_o;
   logic [6:0] taken_vec;
   int errors = 0;
   int n_tests = 0;

   // Free-running 100 MHz clock
   always #5 clk_sys_i = ~clk_sys_i;

   iprb_top i_iprb_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .src_flag_i(src_flag_i),
      .rdata_o(rdata_o), .irq_o(irq_o), .irq_level_o(irq_level_o), .irq_vec_o(irq_vec_o));
   iprb_core_model i_iprb_core_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .irq_i(irq_o), .vec_i(irq_vec_o), .taken_vec_o(taken_vec));

   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task chk_rd(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_rd

   task chk_irq(input logic [10:0] exp);
      n_tests++;
      if ({irq_o, irq_level_o, irq_vec_o} !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
            {irq_o, irq_level_o, irq_vec_o}, exp);
      end
   endtask : chk_irq

   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      chk_rd(rdata_o, exp);
   endtask : rd

   // Request path is flag register then output register
   task settle;
      repeat (3) @(posedge clk_sys_i);
      #1;
   endtask : settle

   task finish_test;
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      for (int i = 0; i < 8; i++)
         rd(i[3:0], IPRB_MASK[i] & 16'h4444);
      rd(4'hF, 16'h0000);
   endtask : t_reset

   // All-ones writes must land only in field bits
   task t_mask;
      for (int i = 0; i < 8; i++)
      begin
         wr(i[3:0], 16'hFFFF);
         rd(i[3:0], IPRB_MASK[i]);
      end
      rd(4'h4, 16'h0007);
      rd(4'h5, 16'h0070);
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
   endtask : t_mask

   // Sources 0 and 2 pending; walk every level, then tie and disable
   task t_arb;
      wr(4'hA, 16'h0005);
      @(posedge clk_sys_i);
      src_flag_i <= 24'h000005;
      @(posedge clk_sys_i);
      src_flag_i <= '0;
      for (int lv = 1; lv < 8; lv++)
      begin
         wr(4'h0, {13'h0000, lv[2:0]});
         settle();
         chk_irq({1'b1, lv[2:0], 7'h0C});
      end
      rd(4'h8, 16'h070C);
      wr(4'h0, 16'h0303);
      settle();
      chk_irq({1'b1, 3'h3, 7'h0C});
      wr(4'h0, 16'h0300);
      settle();
      chk_irq({1'b1, 3'h3, 7'h0E});
      chk_rd({9'h000, taken_vec}, 16'h000E);
      wr(4'h0, 16'h0000);
      settle();
      chk_irq(11'h000);
   endtask : t_arb

   // Win across registers, flag read, single clear, clear-all, then set beats clear
   task t_flag;
      wr(4'hA, 16'h0201);
      wr(4'h0, 16'h0002);
      @(posedge clk_sys_i);
      src_flag_i <= 24'h000200;
      @(posedge clk_sys_i);
      src_flag_i <= '0;
      settle();
      chk_irq({1'b1, 3'h7, 7'h15});
      rd(4'h9, 16'h0205);
      rd(4'hA, 16'h0201);
      wr(4'h9, 16'hFDFF);
      settle();
      chk_irq({1'b1, 3'h2, 7'h0C});
      wr(4'h9, 16'h0000);
      settle();
      chk_irq(11'h000);
      rd(4'h9, 16'h0000);
      @(posedge clk_sys_i);
      addr_i <= 4'h9;
      wdata_i <= 16'h0000;
      wr_i <= 1'b1;
      src_flag_i <= 24'h000001;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      src_flag_i <= '0;
      settle();
      chk_irq({1'b1, 3'h2, 7'h0C});
   endtask : t_flag

   // Watchdog against a hung run
   initial
   begin
      #500000;
      errors++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_reset();
      t_mask();
      t_arb();
      t_flag();
      finish_test();
   end
endmodule : testbench
